// ===== verification/host_frame_src.sv
// Host model: sends framed requests byte by byte on the request stream.
// Assumes in_ready is sampled at the rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none

module host_frame_src (
	input  wire logic       aclk,
	input  wire logic       in_ready,
	output var logic [7:0]  in_byte,
	output var logic        in_valid
);
	// Idle lines at time zero
	initial begin
		in_byte  = 8'h00;
		in_valid = 1'b0;
	end

	// One byte, held until the edge that takes it
	task automatic put(input logic [7:0] b);
		in_byte  <= b;
		in_valid <= 1'b1;
		do @(posedge aclk); while (!in_ready);
	endtask

	// Whole frame around the data bytes; bad flips checksum bit 0
	task automatic frame(input logic [7:0] d[$], input logic bad);
		logic [7:0]  s;
		logic [15:0] n;
		s = 8'h00;
		n = 16'(d.size());
		foreach (d[i]) s += d[i];
		put(8'h7E);
		put(n[15:8]);
		put(n[7:0]);
		foreach (d[i]) put(d[i]);
		put((8'hFF - s) ^ {7'h00, bad});
		// Released line shows the inverse of the last byte
		in_valid <= 1'b0;
		in_byte  <= ~in_byte;
	endtask
endmodule // host_frame_src

`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the request frame decoder.
// Assumes host_frame_src drives the byte stream; registers via AXI4-Lite tasks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", n, e, a); end end

module testbench import frame_dec_pkg::*; ;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, in_byte, pay_byte, pb;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, in_valid, in_ready;
	logic        pay_valid, pay_last, req_valid, drop_valid, plst;
	logic        pr = 1'b1, slow = 1'b0;  // Payload ready, and stall mode for it
	logic [1:0]  bresp, rresp;
	logic [7:0]  q[$];
	req_t        req;
	int          n_fail = 0, cmp_count = 0, pcnt = 0;

	// Clock, 5 ns period
	initial begin
		forever #2.5 aclk = ~aclk;
	end

	api_request_frame_decoder u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
		.s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF),
		.s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
		.s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
		.s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
		.in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready), .pay_byte(pay_byte),
		.pay_valid(pay_valid), .pay_last(pay_last), .pay_ready(pr), .req(req),
		.req_valid(req_valid), .drop_valid(drop_valid));

	host_frame_src u_host (.aclk(aclk), .in_ready(in_ready), .in_byte(in_byte),
		.in_valid(in_valid));

	// Consumer drops ready every other cycle while slow is set
	always @(posedge aclk) pr <= !pr || !slow;

	// Payload monitor: count accepted bytes, keep the last one
	always @(posedge aclk) if (pay_valid && pr) begin
		pcnt <= pcnt + 1;
		pb   <= pay_byte;
		plst <= pay_last;
	end

	// Register write, address and data offered together; bready stays up between writes
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		`CHK("bresp", er, bresp)
	endtask

	// Register read; data checked only on OKAY; rready stays up between reads
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		`CHK("rresp", er, rresp)
		if (er === RESP_OKAY) `CHK("rdata", ev, rdata)
	endtask

	// Wait for the verdict pulse of one frame
	task automatic res(input logic dr);
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (req_valid || drop_valid) break;
		end
		`CHK("verdict", 1'b1, req_valid || drop_valid)
		`CHK("drop", dr, drop_valid)
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#50000;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
		u_host.put(8'h55);
		u_host.frame('{8'h08, 8'h01, 8'h4E, 8'h49}, 1'b0);
		res(1'b0);
		`CHK("kind", KIND_LOCAL, req.kind)
		`CHK("cmd", 16'h4E49, req.cmd)
		`CHK("set", 1'b0, req.is_set)
		`CHK("apply", 1'b1, req.apply_now)
		`CHK("id", 8'h01, req.frame_id)
		`CHK("resp", 1'b1, req.respond)
		`CHK("pcnt", 0, pcnt)
		u_host.frame('{8'h08, 8'h01, 8'h42, 8'h44, 8'h08}, 1'b0);
		res(1'b0);
		`CHK("set", 1'b1, req.is_set)
		`CHK("pbyte", 8'h08, pb)
		`CHK("plast", 1'b1, plst)
		$display("test local done");
		q = '{8'h07, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8, 8'h00, 8'h64, 8'h02,
			8'h44, 8'h4C};
		u_host.frame(q, 1'b0);
		res(1'b0);
		`CHK("kind", KIND_REMOTE, req.kind)
		`CHK("ip", 32'hC0A8_0064, req.ip)
		`CHK("bcast", 1'b0, req.is_bcast)
		`CHK("apply", 1'b1, req.apply_now)
		`CHK("set", 1'b0, req.is_set)
		q[10] = 8'h00;
		q.push_back(8'h03);
		u_host.frame(q, 1'b0);
		res(1'b0);
		`CHK("apply", 1'b0, req.apply_now)
		`CHK("set", 1'b1, req.is_set)
		$display("test remote done");
		pcnt = 0;
		slow <= 1'b1;
		q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
			8'h15, 8'h16};
		u_host.frame(q, 1'b0);
		res(1'b0);
		`CHK("kind", KIND_TX, req.kind)
		`CHK("dest", 64'h0000_0000_FFFF_FFFF, req.dest)
		`CHK("resp", 1'b0, req.respond)
		`CHK("bcast", 1'b1, req.is_bcast)
		`CHK("noack", 1'b1, req.no_ack)
		`CHK("pcnt", 2, pcnt)
		`CHK("pbyte", 8'h16, pb)
		slow <= 1'b0;
		wr(REG_MAC_LO, 32'h2233_4455, RESP_OKAY);
		wr(REG_MAC_HI, 32'h0000_0011, RESP_OKAY);
		for (int i = 0; i < 5; i++) q[5 + i] = 8'(17 * (i + 1));
		u_host.frame(q, 1'b0);
		res(1'b0);
		`CHK("hw", 1'b1, req.is_hw)
		`CHK("bcast", 1'b0, req.is_bcast)
		$display("test transmit done");
		u_host.frame(q, 1'b1);
		res(1'b1);
		q[0] = 8'h20;
		u_host.frame(q, 1'b0);
		res(1'b1);
		rd(REG_LAST, 32'h2000_0000, RESP_OKAY);
		rd(REG_COUNT, 32'h0002_0006, RESP_OKAY);
		rd(8'h40, 32'h0000_0000, RESP_SLVERR);
		wr(8'h40, 32'h0000_0001, RESP_SLVERR);
		wr(REG_COUNT, 32'h0000_0000, RESP_OKAY);
		rd(REG_COUNT, 32'h0000_0000, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		u_host.frame(q, 1'b0);
		rd(REG_STATE, 32'h0000_0001, RESP_OKAY);
		rd(REG_COUNT, 32'h0000_0000, RESP_OKAY);
		$display("test drop and registers done");
		summarize();
	end
endmodule // testbench

`default_nettype wire

// ===== verilog/api_request_frame_decoder.sv
// Request frame decoder: parses delimited request frames byte by byte,
// forwards payload bytes and reports one decoded request per good frame.
// Assumes bytes arrive unescaped and synchronous to aclk; registers over AXI4-Lite.
//
// Operation
// - Frame opens on start delimiter 0x7E
// - Length counts frame data, not checksum
// - Data plus checksum must sum to 0xFF
// - Frame id zero suppresses the response
// - Type 0x00 is 64-bit addressed transmit
// - Low four bytes all 0xFF mean broadcast (not flagged when low six bytes match own address)
// - Low six bytes matching own address: hardware
// - Foreign hardware address read as low IP
// - Option 0x01 disables acknowledgement
// - Transmit payload at most 1392 bytes
// - Type 0x07 is remote parameter command
// - Remote option 0x02 applies changes now
// - Command name two characters, first byte high
// - Remote without parameter is query, else set
// - Type 0x08 is local parameter command
// - Local commands apply changes immediately
// - Local name then checksum means read
// - Local bytes from offset 7 are value
`timescale 1ns/1ps
`default_nettype none

module api_request_frame_decoder
	import frame_dec_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [7:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	input  wire logic [7:0]  in_byte,
	input  wire logic        in_valid,
	output logic             in_ready,
	output logic [7:0]       pay_byte,
	output logic             pay_valid,
	output logic             pay_last,
	input  wire logic        pay_ready,
	output req_t             req,
	output logic             req_valid,
	output logic             drop_valid
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dec_state_t  s;         // Registered state
	dec_state_t  n;         // Next state
	logic        in_fire;   // Input byte accepted
	logic        wr_en;     // Register write strobe
	logic [7:0]  wr_addr;   // Register write address
	logic [31:0] wr_data;   // Register write data
	logic [3:0]  wr_strb;   // Register write lanes
	logic        wr_err;    // Unmapped write
	logic        rd_en;     // Register read strobe
	logic [7:0]  rd_addr;   // Register read address
	logic [31:0] rd_data;   // Register read data
	logic        rd_err;    // Unmapped read
	logic [31:0] wtmp;      // Merged write word
	req_kind_t   k;         // Kind from the type byte
	logic [15:0] start;     // Payload start offset for that kind
	logic [15:0] plen;      // Payload length for that kind
	logic [7:0]  sum_fin;   // Sum including checksum byte

	// Merge written lanes over the old word
	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin  // Unstrobed lanes keep the old byte
			old_w[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
		end
		return old_w;
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	axil_reg_port u_port (  // Every port meets the same-named signal here
		.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
		.s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
		.s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
		.s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .wr_en, .wr_addr, .wr_data, .wr_strb,
		.wr_err, .rd_en, .rd_addr, .rd_data, .rd_err
	);

	// Read mux; unmapped addresses answer with an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		case (rd_addr)
			REG_CTRL:   rd_data = {31'h0, s.en};
			REG_MAC_LO: rd_data = s.mac[31:0];
			REG_MAC_HI: rd_data = {16'h0000, s.mac[47:32]};
			REG_COUNT:  rd_data = {s.err_cnt, s.ok_cnt};
			REG_LAST:   rd_data = s.last;
			REG_STATE:  rd_data = {27'h0, s.st};
			default:    rd_err  = 1'b1;
		endcase
	end

	// Writes outside the map are refused
	assign wr_err = !(wr_addr inside {REG_CTRL, REG_MAC_LO, REG_MAC_HI, REG_COUNT,
		REG_LAST, REG_STATE});

	// ----------------------------------------------------------------
	// Stream ports
	// ----------------------------------------------------------------
	assign in_ready   = !s.pay_v || pay_ready;  // Stall while payload unread
	assign in_fire    = in_valid && in_ready;
	assign pay_byte   = s.pay_b;
	assign pay_valid  = s.pay_v;
	assign pay_last   = s.pay_last;
	assign req        = s.req;
	assign req_valid  = s.req_v;
	assign drop_valid = s.drop_v;

	// Kind, payload start and length chosen by the type byte
	always_comb begin
		k     = KIND_NONE;
		start = 16'h0000;
		case (in_byte)
			TYPE_TX64: begin
				k     = KIND_TX;
				start = OFS_TX_DATA;
			end
			TYPE_REMOTE: begin
				k     = KIND_REMOTE;
				start = OFS_RM_PARAM;
			end
			TYPE_LOCAL: begin
				k     = KIND_LOCAL;
				start = OFS_LC_PARAM;
			end
			default: k = KIND_NONE;
		endcase
		plen = s.len + OFS_TYPE - start;
	end

	// ----------------------------------------------------------------
	// Parser and register file
	// ----------------------------------------------------------------
	always_comb begin
		n       = s;
		wtmp    = 32'h0000_0000;
		sum_fin = s.sum + in_byte;
		n.req_v  = 1'b0;
		n.drop_v = 1'b0;
		if (s.pay_v && pay_ready) begin  // Payload byte consumed
			n.pay_v = 1'b0;
		end
		if (wr_en) begin  // Software writes
			case (wr_addr)
				REG_CTRL: begin
					wtmp = merge({31'h0, s.en}, wr_data, wr_strb);
					n.en = wtmp[CTRL_EN_BIT];
				end
				REG_MAC_LO: n.mac[31:0] = merge(s.mac[31:0], wr_data, wr_strb);
				REG_MAC_HI: begin
					wtmp = merge({16'h0000, s.mac[47:32]}, wr_data, wr_strb);
					n.mac[47:32] = wtmp[15:0];
				end
				REG_COUNT: begin  // Any write clears; a count event still lands
					n.ok_cnt  = 16'h0000;
					n.err_cnt = 16'h0000;
				end
				default: wtmp = 32'h0000_0000;
			endcase
		end
		if (in_fire) begin
			case (s.st)
				ST_IDLE: begin  // Bytes before a delimiter are discarded
					if (s.en && in_byte == START_DELIM) begin
						n.st  = ST_LEN_HI;
						n.sum = 8'h00;
					end
				end
				ST_LEN_HI: begin
					n.len[15:8] = in_byte;
					n.st        = ST_LEN_LO;
				end
				ST_LEN_LO: begin
					n.len[7:0] = in_byte;
					n.pos      = OFS_TYPE;
					n.kind     = KIND_NONE;
					n.bad      = 1'b0;
					n.dest     = 64'h0000_0000_0000_0000;
					n.opt      = 8'h00;
					n.cmd      = 16'h0000;
					n.id       = 8'h00;
					if ({s.len[15:8], in_byte} == 16'h0000) begin  // Empty frame
						n.bad = 1'b1;
						n.st  = ST_CSUM;
					end else begin
						n.st = ST_BODY;
					end
				end
				ST_BODY: begin
					n.sum = sum_fin;
					n.pos = s.pos + 16'h0001;
					if (s.pos == OFS_TYPE) begin  // Type byte fixes layout
						n.type_b = in_byte;
						n.kind   = k;
						n.start  = start;
						n.plen   = plen;
						n.bad    = (k == KIND_NONE) || ((s.len + OFS_TYPE) < start)
							|| (k == KIND_TX && plen > MAX_PAYLOAD);
					end else begin
						if (s.pos == OFS_ID) begin
							n.id = in_byte;
						end
						if (s.kind != KIND_LOCAL && s.pos >= OFS_DEST_LO
							&& s.pos <= OFS_DEST_HI) begin  // Destination, high byte first
							n.dest = {s.dest[55:0], in_byte};
						end
						if ((s.kind == KIND_TX && s.pos == OFS_TX_OPT)
							|| (s.kind == KIND_REMOTE && s.pos == OFS_RM_OPT)) begin
							n.opt = in_byte;
						end
						if ((s.kind == KIND_REMOTE && s.pos == OFS_RM_CMD_HI)
							|| (s.kind == KIND_LOCAL && s.pos == OFS_LC_CMD_HI)) begin
							n.cmd[15:8] = in_byte;
						end
						if ((s.kind == KIND_REMOTE && s.pos == OFS_RM_CMD_LO)
							|| (s.kind == KIND_LOCAL && s.pos == OFS_LC_CMD_LO)) begin
							n.cmd[7:0] = in_byte;
						end
						if (!s.bad && s.pos >= s.start) begin  // Forward payload or value
							n.pay_v    = 1'b1;
							n.pay_b    = in_byte;
							n.pay_last = (s.pos == s.len + OFS_LEN_LSB);
						end
					end
					if (s.pos == s.len + OFS_LEN_LSB) begin  // Last frame data byte
						n.st = ST_CSUM;
					end
				end
				ST_CSUM: begin
					n.st   = ST_IDLE;
					n.last = {s.type_b, s.id, s.cmd};
					if (sum_fin == CSUM_GOOD && !s.bad) begin
						n.req_v             = 1'b1;
						n.ok_cnt            = n.ok_cnt + 16'h0001;
						n.req.kind          = s.kind;
						n.req.frame_id      = s.id;
						n.req.respond       = (s.id != 8'h00);
						n.req.dest          = s.dest;
						n.req.is_hw         = (s.kind != KIND_LOCAL)
							&& (s.dest[47:0] == s.mac);
						n.req.is_bcast      = (s.kind != KIND_LOCAL)
							&& !(s.dest[47:0] == s.mac)
							&& (s.dest[31:0] == BCAST_IP);
						n.req.ip            = s.dest[31:0];
						n.req.no_ack        = (s.kind == KIND_TX)
							&& ((s.opt & OPT_NO_ACK) != 8'h00);
						n.req.apply_now     = (s.kind == KIND_LOCAL)
							|| (s.kind == KIND_REMOTE
							&& (s.opt & OPT_APPLY) != 8'h00);
						n.req.cmd           = s.cmd;
						n.req.param_len     = s.plen;
						n.req.is_set        = (s.plen != 16'h0000);
					end else begin  // Bad sum, short, oversize or unknown type
						n.drop_v  = 1'b1;
						n.err_cnt = n.err_cnt + 16'h0001;
					end
				end
				default: n.st = ST_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s    <= '0;
			s.st <= ST_IDLE;
			s.en <= CTRL_EN_RST;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_delim;
		s.st == ST_IDLE && in_fire && s.en && in_byte == START_DELIM;
	endsequence

	sequence s_len_done;
		s.st == ST_LEN_LO && in_fire && {s.len[15:8], in_byte} != 16'h0000;
	endsequence

	a_frame_start: assert property (s_delim |=> s.st == ST_LEN_HI)
		else $error("delimiter did not open a frame");
	a_len_to_body: assert property (s_len_done |=> s.st == ST_BODY && s.pos == OFS_TYPE)
		else $error("length did not lead to frame data");
	a_csum_good: assert property (req_valid |-> 8'($past(s.sum) + $past(in_byte)) == CSUM_GOOD)
		else $error("request reported with bad checksum");
	a_respond_id: assert property (req_valid |-> req.respond == (req.frame_id != 8'h00))
		else $error("response flag disagrees with frame id");
	a_bcast_low: assert property (req_valid && req.kind != KIND_LOCAL && !req.is_hw
		&& req.ip == BCAST_IP |-> req.is_bcast)
		else $error("broadcast destination not flagged");
	a_hw_match: assert property (req_valid && req.kind != KIND_LOCAL
		|-> req.is_hw == (req.dest[47:0] == s.mac))
		else $error("hardware address match wrong");
	a_ip_low: assert property (req_valid |-> req.ip == req.dest[31:0])
		else $error("ip not taken from low word");
	a_local_apply: assert property (req_valid && req.kind == KIND_LOCAL |-> req.apply_now)
		else $error("local command not applied at once");
	a_query_set: assert property (req_valid |-> req.is_set == (req.param_len != 16'h0000))
		else $error("query or set decided wrongly");
	a_known_pay: assert property (pay_valid |-> s.kind != KIND_NONE && !s.bad)
		else $error("payload forwarded from dropped frame");
	a_pay_hold: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay_byte))
		else $error("payload byte lost under stall");

endmodule // api_request_frame_decoder

`default_nettype wire

// ===== verilog/axil_reg_port.sv
// AXI4-Lite slave front end turning bus transfers into register strobes.
// Assumes the register file answers wr_err, rd_data and rd_err combinationally.
`timescale 1ns/1ps
`default_nettype none

module axil_reg_port
	import frame_dec_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [7:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);

	axil_state_t s;  // Registered state
	axil_state_t n;  // Next state

	// ----------------------------------------------------------------
	// Handshakes and strobes
	// ----------------------------------------------------------------
	assign s_axil_awready = !s.aw_v;
	assign s_axil_wready  = !s.w_v;
	assign s_axil_arready = !s.r_v;
	assign s_axil_bvalid  = s.b_v;
	assign s_axil_bresp   = s.b_r;
	assign s_axil_rvalid  = s.r_v;
	assign s_axil_rdata   = s.r_d;
	assign s_axil_rresp   = s.r_r;
	// Write fires once both halves are held and no response is pending
	assign wr_en   = s.aw_v && s.w_v && !s.b_v;
	assign wr_addr = {s.aw_a[7:2], 2'b00};
	assign wr_data = s.w_d;
	assign wr_strb = s.w_s;
	assign rd_en   = s_axil_arvalid && !s.r_v;
	assign rd_addr = {s_axil_araddr[7:2], 2'b00};

	// Next state
	always_comb begin
		n = s;
		if (s_axil_awvalid && !s.aw_v) begin  // Address taken in any order
			n.aw_v = 1'b1;
			n.aw_a = s_axil_awaddr;
		end
		if (s_axil_wvalid && !s.w_v) begin  // Data taken in any order
			n.w_v = 1'b1;
			n.w_d = s_axil_wdata;
			n.w_s = s_axil_wstrb;
		end
		if (wr_en) begin  // Response follows both halves
			n.aw_v = 1'b0;
			n.w_v  = 1'b0;
			n.b_v  = 1'b1;
			n.b_r  = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (s.b_v && s_axil_bready) begin
			n.b_v = 1'b0;
		end
		if (rd_en) begin  // Read data captured at the address edge
			n.r_v = 1'b1;
			n.r_d = rd_data;
			n.r_r = rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s.r_v && s_axil_rready) begin
			n.r_v = 1'b0;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule // axil_reg_port

`default_nettype wire

// ===== verilog/frame_dec_pkg.sv
// Constants, types and state carriers shared by the request frame decoder.
// Assumes a single 200 MHz clock domain and byte-wide request input.
`default_nettype none

package frame_dec_pkg;

	// ----------------------------------------------------------------
	// Frame framing and type codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  START_DELIM  = 8'h7E;       // Opens every frame
	localparam logic [7:0]  TYPE_TX64    = 8'h00;       // 64-bit addressed transmit
	localparam logic [7:0]  TYPE_REMOTE  = 8'h07;       // Remote parameter command
	localparam logic [7:0]  TYPE_LOCAL   = 8'h08;       // Local parameter command
	localparam logic [7:0]  OPT_NO_ACK   = 8'h01;       // Transmit option: no ack
	localparam logic [7:0]  OPT_APPLY    = 8'h02;       // Remote option: apply now
	localparam logic [7:0]  CSUM_GOOD    = 8'hFF;       // Data plus checksum sum
	localparam logic [31:0] BCAST_IP     = 32'hFFFF_FFFF; // Broadcast low word
	localparam logic [15:0] MAX_PAYLOAD  = 16'h0570;    // 1392 bytes at most

	// ----------------------------------------------------------------
	// Byte offsets within a frame, delimiter at offset 0
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_LEN_LSB   = 16'h0002;
	localparam logic [15:0] OFS_TYPE      = 16'h0003;
	localparam logic [15:0] OFS_ID        = 16'h0004;
	localparam logic [15:0] OFS_DEST_LO   = 16'h0005;  // First destination byte
	localparam logic [15:0] OFS_DEST_HI   = 16'h000C;  // Last destination byte
	localparam logic [15:0] OFS_TX_OPT    = 16'h000D;
	localparam logic [15:0] OFS_TX_DATA   = 16'h000E;
	localparam logic [15:0] OFS_RM_OPT    = 16'h000D;
	localparam logic [15:0] OFS_RM_CMD_HI = 16'h000E;
	localparam logic [15:0] OFS_RM_CMD_LO = 16'h000F;
	localparam logic [15:0] OFS_RM_PARAM  = 16'h0010;
	localparam logic [15:0] OFS_LC_CMD_HI = 16'h0005;
	localparam logic [15:0] OFS_LC_CMD_LO = 16'h0006;
	localparam logic [15:0] OFS_LC_PARAM  = 16'h0007;

	// ----------------------------------------------------------------
	// Register map, byte addresses, and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL    = 8'h00;  // Bit 0: decoder enable
	localparam logic [7:0]  REG_MAC_LO  = 8'h04;  // Own hardware address [31:0]
	localparam logic [7:0]  REG_MAC_HI  = 8'h08;  // Own hardware address [47:32]
	localparam logic [7:0]  REG_COUNT   = 8'h0C;  // Bad and good frame counts
	localparam logic [7:0]  REG_LAST    = 8'h10;  // Last type, id and command
	localparam logic [7:0]  REG_STATE   = 8'h14;  // Parser state
	localparam logic        CTRL_EN_RST = 1'b1;
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_LEN_HI = 5'h02,
		ST_LEN_LO = 5'h04,
		ST_BODY   = 5'h08,
		ST_CSUM   = 5'h10
	} parse_state_t;

	typedef enum logic [1:0] {
		KIND_NONE   = 2'h0,
		KIND_TX     = 2'h1,
		KIND_REMOTE = 2'h2,
		KIND_LOCAL  = 2'h3
	} req_kind_t;

	// Decoded request handed downstream
	typedef struct packed {
		req_kind_t   kind;
		logic [7:0]  frame_id;
		logic        respond;    // Frame id non-zero
		logic [63:0] dest;
		logic        is_hw;      // Low six bytes match own address
		logic        is_bcast;
		logic [31:0] ip;
		logic        no_ack;
		logic        apply_now;
		logic [15:0] cmd;        // First character in upper byte
		logic        is_set;     // Parameter bytes present
		logic [15:0] param_len;  // Payload or parameter byte count
	} req_t;

	// Bus slave state
	typedef struct packed {
		logic        aw_v;
		logic [7:0]  aw_a;
		logic        w_v;
		logic [31:0] w_d;
		logic [3:0]  w_s;
		logic        b_v;
		logic [1:0]  b_r;
		logic        r_v;
		logic [31:0] r_d;
		logic [1:0]  r_r;
	} axil_state_t;

	// Decoder state
	typedef struct packed {
		parse_state_t st;
		logic [15:0]  len;
		logic [15:0]  pos;
		logic [7:0]   sum;
		req_kind_t    kind;
		logic [7:0]   type_b;
		logic         bad;
		logic [7:0]   id;
		logic [63:0]  dest;
		logic [7:0]   opt;
		logic [15:0]  cmd;
		logic [15:0]  start;
		logic [15:0]  plen;
		logic         pay_v;
		logic [7:0]   pay_b;
		logic         pay_last;
		req_t         req;
		logic         req_v;
		logic         drop_v;
		logic         en;
		logic [47:0]  mac;
		logic [15:0]  ok_cnt;
		logic [15:0]  err_cnt;
		logic [31:0]  last;
	} dec_state_t;

endpackage

`default_nettype wire
